// *** rtl/dctg_guard.sv ***
// Command gate that keeps DRAM command spacing within the timing limits
`timescale 1ns/10ps
`default_nettype none
module dctg_guard
  import dctg_pkg::*;
#(
  parameter int unsigned GRADE       = 0,
  parameter int unsigned USE_RRD_ALT = 0,
  parameter int unsigned NBANK       = DCTG_NBANK,
  parameter int unsigned XSR_CYC     = DCTG_XSR_CYC,
  parameter int unsigned RAS_MAX_CYC = DCTG_RAS_MAX_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Command requests
  input  wire logic             req_valid,
  input  wire dctg_req_type     req,
  output var  logic             req_ack,
  // Write data completion
  input  wire dctg_wrdone_type  wr_last,
  // Command to the DRAM
  output var  dctg_req_type     dram_cmd,
  // Status
  output var  logic             refresh_due,
  output var  logic [NBANK-1:0] row_overdue,
  output var  logic             self_refresh
);

  localparam int unsigned TW = DCTG_TMR_W;
  localparam int unsigned RRD_MAX =
    (DCTG_RRD_ALT_CYC > DCTG_RRD_TBL[GRADE]) ?
    DCTG_RRD_ALT_CYC : DCTG_RRD_TBL[GRADE];
  localparam int unsigned N_RRD =
    (USE_RRD_ALT != 0) ? RRD_MAX : DCTG_RRD_TBL[GRADE];
  localparam int unsigned N_RFC  = DCTG_RFC_TBL[GRADE];
  localparam int unsigned N_RCDR = DCTG_RCDR_TBL[GRADE];
  localparam int unsigned N_RCDW = DCTG_RCDW_TBL[GRADE];
  localparam int unsigned N_CDLR = DCTG_CDLR_TBL[GRADE];
  localparam int unsigned N_MRD  = DCTG_MRD_TBL[GRADE];
  localparam int unsigned N_RAS  = DCTG_RAS_TBL[GRADE];

  // ==========================================================
  // Timer reload values, one less than the spacing
  logic [TW-1:0] bval [DCTG_NKIND];
  logic [TW-1:0] gval [DCTG_NGLOB];

  assign bval[K_RCDR]   = TW'(N_RCDR - 1);
  assign bval[K_RCDW]   = TW'(N_RCDW - 1);
  assign bval[K_RASMIN] = TW'(N_RAS - 1);
  assign bval[K_RC]     = TW'(DCTG_RC_TBL[GRADE] - 1);
  assign bval[K_RP]     = TW'(DCTG_RP_TBL[GRADE] - 1);
  assign bval[K_WRPRE]  = TW'(DCTG_WR_TBL[GRADE] - 1);
  assign bval[K_DAL]    = TW'(DCTG_DAL_TBL[GRADE] - 1);
  assign bval[K_RASMAX] = TW'(RAS_MAX_CYC - 1);
  assign gval[G_RRD]    = TW'(N_RRD - 1);
  assign gval[G_RFC]    = TW'(N_RFC - 1);
  assign gval[G_CDLR]   = TW'(N_CDLR - 1);
  assign gval[G_MRD]    = TW'(N_MRD - 1);
  assign gval[G_XSR]    = TW'(XSR_CYC - 1);
  assign gval[G_XSNR]   = TW'(DCTG_XSNR_CYC - 1);

  // ==========================================================
  // State
  dctg_state_type   state_r;
  dctg_state_type   state_nxt;
  logic [NBANK-1:0] open_r;
  logic [NBANK-1:0] open_nxt;
  logic [1:0]       faw_ptr_r;
  logic             ack_r;
  dctg_req_type     cmd_r;
  dctg_req_type     cmd_nxt;
  logic             due_r;
  logic             due_nxt;
  logic [NBANK-1:0] overdue_r;
  logic             selfref_r;

  logic [NBANK-1:0] bload [DCTG_NKIND];
  logic [NBANK-1:0] bzero [DCTG_NKIND];
  logic             gload [DCTG_NGLOB];
  logic             gzero [DCTG_NGLOB];
  logic             faw_load [DCTG_FAW_ACTS];
  logic             faw_zero [DCTG_FAW_ACTS];
  logic             ref_zero;

  // ==========================================================
  // Request decode
  wire logic [DCTG_BANK_W-1:0] rb = req.bank;
  wire logic is_act = (req.cmd == CMD_ACT);
  wire logic is_rd  = (req.cmd == CMD_RD);
  wire logic is_wr  = (req.cmd == CMD_WR);
  wire logic is_pre = (req.cmd == CMD_PRE);
  wire logic is_ref = (req.cmd == CMD_REF);
  wire logic is_mrs = (req.cmd == CMD_MRS);
  wire logic is_sre = (req.cmd == CMD_SRE);
  wire logic is_srx = (req.cmd == CMD_SRX);
  wire logic in_run = (state_r == ST_RUN);
  wire logic all_closed = (open_r == '0);
  wire logic bank_open  = open_r[rb];
  wire logic [NBANK-1:0] req_oh = NBANK'(1) << rb;
  wire logic [NBANK-1:0] wl_oh  =
    wr_last.valid ? (NBANK'(1) << wr_last.bank) : '0;

  // The window check is dropped only in the wider spacing mode
  wire logic faw_ok = (USE_RRD_ALT != 0) || faw_zero[faw_ptr_r];

  wire logic act_ok = !bank_open && bzero[K_RC][rb] &&
                      bzero[K_RP][rb] &&
                      bzero[K_DAL][rb] &&
                      gzero[G_RRD] && faw_ok &&
                      gzero[G_RFC];
  wire logic rd_ok  = bank_open && bzero[K_RCDR][rb] &&
                      gzero[G_CDLR] &&
                      gzero[G_XSR];
  wire logic wr_ok  = bank_open && bzero[K_RCDW][rb];
  wire logic pre_ok = bank_open && bzero[K_RASMIN][rb] &&
                      bzero[K_WRPRE][rb];
  wire logic ref_ok = all_closed && gzero[G_RFC] &&
                      (&bzero[K_RP]);
  wire logic idle_ok = all_closed && gzero[G_RFC];

  // Every command but self refresh exit waits mode recovery; non-reads wait the short exit
  wire logic run_ok = gzero[G_MRD] &&
                      (is_rd || gzero[G_XSNR]);

  wire logic cmd_ok =
    !in_run ? is_srx :
    run_ok && ((is_act && act_ok) || (is_rd && rd_ok) ||
               (is_wr && wr_ok)   || (is_pre && pre_ok) ||
               (is_ref && ref_ok) || (is_mrs && all_closed) ||
               (is_sre && idle_ok) || (req.cmd == CMD_NOP));

  // No acceptance in the ack cycle, so a held request issues once
  wire logic acc = req_valid && !ack_r && cmd_ok;

  wire logic [NBANK-1:0] act_oh = (acc && is_act) ? req_oh : '0;
  wire logic [NBANK-1:0] pre_oh = (acc && is_pre) ? req_oh : '0;
  wire logic [NBANK-1:0] dal_oh = wr_last.autopre ? wl_oh : '0;

  // ==========================================================
  // Timer triggers
  assign bload[K_RCDR]   = act_oh;
  assign bload[K_RCDW]   = act_oh;
  assign bload[K_RASMIN] = act_oh;
  assign bload[K_RC]     = act_oh;
  assign bload[K_RASMAX] = act_oh;
  assign bload[K_RP]     = pre_oh;
  assign bload[K_WRPRE]  = wl_oh;
  assign bload[K_DAL]    = dal_oh;
  assign gload[G_RRD]    = acc && is_act;
  assign gload[G_RFC]    = acc && is_ref;
  assign gload[G_CDLR]   = wr_last.valid;
  assign gload[G_MRD]    = acc && is_mrs;
  assign gload[G_XSR]    = acc && is_srx;
  assign gload[G_XSNR]   = acc && is_srx;

  genvar gb, gk;
  generate
    for (gb = 0; gb < NBANK; gb++) begin : g_bank
      for (gk = 0; gk < DCTG_NKIND; gk++) begin : g_kind
        dctg_timer #(.W(TW)) u_tmr (
          .clk      (clk),
          .rst_n    (rst_n),
          .load     (bload[gk][gb]),
          .load_val (bval[gk]),
          .expired  (bzero[gk][gb])
        );
      end
    end
    for (gk = 0; gk < DCTG_NGLOB; gk++) begin : g_glob
      dctg_timer #(.W(TW)) u_tmr (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (gload[gk]),
        .load_val (gval[gk]),
        .expired  (gzero[gk])
      );
    end
    // Each slot remembers one of the last four activates
    for (gk = 0; gk < DCTG_FAW_ACTS; gk++) begin : g_faw
      assign faw_load[gk] = acc && is_act && (faw_ptr_r == 2'(gk));
      dctg_timer #(.W(TW)) u_tmr (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (faw_load[gk]),
        .load_val (TW'(DCTG_FAW_CYC - 1)),
        .expired  (faw_zero[gk])
      );
    end
  endgenerate

  // Free running so the refresh rate does not drift with issue delay
  dctg_timer #(.W(TW)) u_ref_tmr (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (ref_zero),
    .load_val (TW'(DCTG_REF_CYC - 1)),
    .expired  (ref_zero)
  );

  // ==========================================================
  // Next state
  assign open_nxt = (open_r | act_oh) & ~pre_oh & ~dal_oh;
  assign state_nxt = (acc && is_sre) ? ST_SELFREF :
                     (acc && is_srx) ? ST_RUN : state_r;
  assign cmd_nxt.cmd  = acc ? req.cmd : CMD_NOP;
  assign cmd_nxt.bank = acc ? req.bank : '0;
  // A new expiry wins over the refresh that clears the flag
  assign due_nxt = (ref_zero && in_run) ||
                   (due_r && !(acc && is_ref));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= ST_RUN;
      open_r    <= '0;
      faw_ptr_r <= '0;
      ack_r     <= 1'b0;
      cmd_r     <= '{cmd: CMD_NOP, bank: '0};
      due_r     <= 1'b0;
      overdue_r <= '0;
      selfref_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      open_r    <= open_nxt;
      faw_ptr_r <= faw_ptr_r + 2'((acc && is_act) ? 1 : 0);
      ack_r     <= acc;
      cmd_r     <= cmd_nxt;
      due_r     <= due_nxt;
      overdue_r <= open_r & bzero[K_RASMAX];
      selfref_r <= (state_nxt == ST_SELFREF);
    end
  end

  assign req_ack      = ack_r;
  assign dram_cmd     = cmd_r;
  assign refresh_due  = due_r;
  assign row_overdue  = overdue_r;
  assign self_refresh = selfref_r;

  // ==========================================================
  // Checks: cycles since each event, saturating
  localparam int unsigned NEV = 5;
  localparam int unsigned E_ACT = 0;
  localparam int unsigned E_REF = 1;
  localparam int unsigned E_MRS = 2;
  localparam int unsigned E_SRX = 3;
  localparam int unsigned E_WL  = 4;
  logic [TW-1:0] since_r   [NEV];
  logic [TW-1:0] since_b_r [NBANK];
  logic          ev        [NEV];

  assign ev[E_ACT] = (cmd_r.cmd == CMD_ACT);
  assign ev[E_REF] = (cmd_r.cmd == CMD_REF);
  assign ev[E_MRS] = (cmd_r.cmd == CMD_MRS);
  assign ev[E_SRX] = (cmd_r.cmd == CMD_SRX);
  assign ev[E_WL]  = wr_last.valid;

  generate
    for (gk = 0; gk < NEV; gk++) begin : g_since
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          since_r[gk] <= '1;
        end else if (ev[gk]) begin
          since_r[gk] <= TW'(1);
        end else if (since_r[gk] != '1) begin
          since_r[gk] <= since_r[gk] + TW'(1);
        end
      end
    end
    for (gb = 0; gb < NBANK; gb++) begin : g_since_b
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          since_b_r[gb] <= '1;
        end else if (ev[E_ACT] && cmd_r.bank == DCTG_BANK_W'(gb)) begin
          since_b_r[gb] <= TW'(1);
        end else if (since_b_r[gb] != '1) begin
          since_b_r[gb] <= since_b_r[gb] + TW'(1);
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  wire logic o_act = (cmd_r.cmd == CMD_ACT);
  wire logic o_rd  = (cmd_r.cmd == CMD_RD);
  wire logic o_any = (cmd_r.cmd != CMD_NOP);

  a_act_spacing: assert property (o_act |-> since_r[E_ACT] >= N_RRD)
    else $error("activates too close");
  a_ref_recovery: assert property (
    (o_act || ev[E_REF]) |-> since_r[E_REF] >= N_RFC)
    else $error("refresh cycle wait violated");
  a_mrs_recovery: assert property (
    o_any |-> since_r[E_MRS] >= N_MRD)
    else $error("mode set recovery violated");
  a_srx_read: assert property (o_rd |-> since_r[E_SRX] >= XSR_CYC)
    else $error("read too soon after self refresh exit");
  a_srx_other: assert property (
    (o_any && !o_rd) |-> since_r[E_SRX] >= DCTG_XSNR_CYC)
    else $error("command too soon after self refresh exit");
  a_write_read: assert property (o_rd |-> since_r[E_WL] > N_CDLR)
    else $error("read too soon after write data");
  a_act_read: assert property (
    o_rd |-> since_b_r[cmd_r.bank] >= N_RCDR)
    else $error("read too soon after activate");
  a_act_write: assert property (
    (cmd_r.cmd == CMD_WR) |-> since_b_r[cmd_r.bank] >= N_RCDW)
    else $error("write too soon after activate");
  a_row_min_open: assert property (
    (cmd_r.cmd == CMD_PRE) |-> since_b_r[cmd_r.bank] >= N_RAS)
    else $error("precharge before row open time");
  a_refresh_flag: assert property (
    (refresh_due && !(req_valid && is_ref)) |=> refresh_due)
    else $error("refresh due flag lost");

  c_act_then_read: cover property (o_act ##[1:40] o_rd);
  c_self_refresh: cover property (self_refresh ##1 !self_refresh);
  c_refresh_due: cover property ($rose(refresh_due));

endmodule
`default_nettype wire

// *** rtl/dctg_pkg.sv ***
// Constants and types for the DRAM command timing guard
package dctg_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned DCTG_NGRADE = 4;
  localparam int unsigned DCTG_NBANK  = 8;
  localparam int unsigned DCTG_BANK_W = 3;
  localparam int unsigned DCTG_TMR_W  = 17;

  // ==========================================================
  // Cycle tables, one entry per speed grade, fastest first
  typedef int unsigned dctg_tbl_type [DCTG_NGRADE];
  localparam dctg_tbl_type DCTG_RFC_TBL  = '{52, 45, 45, 39};
  localparam dctg_tbl_type DCTG_RCDR_TBL = '{14, 12, 12, 10};
  localparam dctg_tbl_type DCTG_RCDW_TBL = '{10, 8, 8, 6};
  localparam dctg_tbl_type DCTG_RRD_TBL  = '{10, 8, 8, 8};
  localparam dctg_tbl_type DCTG_WR_TBL   = '{13, 11, 11, 10};
  localparam dctg_tbl_type DCTG_CDLR_TBL = '{7, 6, 6, 5};
  localparam dctg_tbl_type DCTG_MRD_TBL  = '{9, 7, 7, 6};
  localparam dctg_tbl_type DCTG_DAL_TBL  = '{25, 21, 21, 19};
  localparam dctg_tbl_type DCTG_RAS_TBL  = '{29, 25, 25, 22};
  localparam dctg_tbl_type DCTG_RC_TBL   = '{41, 35, 35, 31};
  localparam dctg_tbl_type DCTG_RP_TBL   = '{12, 10, 10, 9};

  // ==========================================================
  // Grade independent figures
  localparam int unsigned DCTG_FAW_CYC      = 40;
  localparam int unsigned DCTG_FAW_ACTS     = 4;
  localparam int unsigned DCTG_XSR_CYC      = 20000;
  localparam int unsigned DCTG_XSNR_CYC     = 100;
  localparam int unsigned DCTG_RAS_MAX_CYC  = 100000;
  localparam int unsigned DCTG_CLK_PS       = 5000;
  localparam int unsigned DCTG_RRD_ALT_PS   = 12000;
  localparam int unsigned DCTG_REF_INT_NS   = 3900;
  localparam int unsigned DCTG_PS_PER_NS    = 1000;
  // Least time: round up
  localparam int unsigned DCTG_RRD_ALT_CYC  =
    (DCTG_RRD_ALT_PS + DCTG_CLK_PS - 1) / DCTG_CLK_PS;
  // Longest time: round down
  localparam int unsigned DCTG_REF_CYC      =
    (DCTG_REF_INT_NS * DCTG_PS_PER_NS) / DCTG_CLK_PS;

  // ==========================================================
  // Per-bank timer kinds
  localparam int unsigned K_RCDR   = 0;
  localparam int unsigned K_RCDW   = 1;
  localparam int unsigned K_RASMIN = 2;
  localparam int unsigned K_RC     = 3;
  localparam int unsigned K_RP     = 4;
  localparam int unsigned K_WRPRE  = 5;
  localparam int unsigned K_DAL    = 6;
  localparam int unsigned K_RASMAX = 7;
  localparam int unsigned DCTG_NKIND = 8;

  // Global timer kinds
  localparam int unsigned G_RRD    = 0;
  localparam int unsigned G_RFC    = 1;
  localparam int unsigned G_CDLR   = 2;
  localparam int unsigned G_MRD    = 3;
  localparam int unsigned G_XSR    = 4;
  localparam int unsigned G_XSNR   = 5;
  localparam int unsigned DCTG_NGLOB = 6;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
    CMD_REF, CMD_MRS, CMD_SRE, CMD_SRX
  } dctg_cmd_type;

  typedef enum logic {ST_RUN, ST_SELFREF} dctg_state_type;

  typedef struct packed {
    dctg_cmd_type           cmd;
    logic [DCTG_BANK_W-1:0] bank;
  } dctg_req_type;

  typedef struct packed {
    logic                   valid;
    logic [DCTG_BANK_W-1:0] bank;
    logic                   autopre;
  } dctg_wrdone_type;

endpackage

// *** rtl/dctg_timer.sv ***
// Loadable down counter that flags when its wait has run out
`timescale 1ns/10ps
`default_nettype none
module dctg_timer
  import dctg_pkg::*;
#(
  parameter int unsigned W = DCTG_TMR_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              expired
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Holds at zero once run out
  assign cnt_nxt = load ? load_val :
                   (cnt_r == '0) ? cnt_r : cnt_r - W'(1);
  assign expired = (cnt_r == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// *** test/dctg_dram_model.sv ***
// Behavioural DRAM that counts commands issued before their spacing is met
`timescale 1ns/10ps
`default_nettype none
module dctg_dram_model
  import dctg_pkg::*;
#(
  parameter int unsigned GRADE   = 0,
  parameter int unsigned XSR_CYC = DCTG_XSR_CYC
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Command bus and write data completion
  input  wire dctg_req_type    cmd,
  input  wire dctg_wrdone_type wr_last,
  // Spacing faults seen
  output var  int              violations
);
  // ==========================================================
  // Event times, in edges
  localparam int NEVER = -100000;
  int now;
  int t_ref;
  int t_mrs;
  int t_srx;
  int t_act_any;
  int t_wl_any;
  int b;
  int t_act [DCTG_NBANK];
  int t_pre [DCTG_NBANK];
  int t_wl  [DCTG_NBANK];
  int t_dal [DCTG_NBANK];
  int acts  [$];

  task automatic need(input int since, input int n);
    if (now < since + n) violations++;
  endtask

  initial violations = 0;

  // ==========================================================
  // Command shown since the previous edge is stamped with now
  always @(posedge clk) begin
    b = int'(cmd.bank);
    if (!rst_n) begin
      {t_ref, t_mrs, t_srx, t_act_any, t_wl_any} = {5{NEVER}};
      foreach (t_act[i]) begin
        t_act[i] = NEVER;
        t_pre[i] = NEVER;
        t_wl[i] = NEVER;
        t_dal[i] = NEVER;
      end
      acts.delete();
    end else begin
      if (cmd.cmd != CMD_NOP) need(t_mrs, DCTG_MRD_TBL[GRADE]);
      if (!(cmd.cmd inside {CMD_NOP, CMD_RD}))
        need(t_srx, DCTG_XSNR_CYC);
      case (cmd.cmd)
        CMD_ACT: begin
          need(t_ref, DCTG_RFC_TBL[GRADE]);
          need(t_act_any, DCTG_RRD_TBL[GRADE]);
          need(t_dal[b], DCTG_DAL_TBL[GRADE]);
          need(t_pre[b], DCTG_RP_TBL[GRADE]);
          need(t_act[b], DCTG_RC_TBL[GRADE]);
          if (acts.size() >= DCTG_FAW_ACTS)
            need(acts[acts.size() - DCTG_FAW_ACTS], DCTG_FAW_CYC);
          acts.push_back(now);
          t_act[b] = now;
          t_act_any = now;
        end
        CMD_RD: begin
          need(t_act[b], DCTG_RCDR_TBL[GRADE]);
          need(t_wl_any, DCTG_CDLR_TBL[GRADE]);
          need(t_srx, XSR_CYC);
        end
        CMD_WR: need(t_act[b], DCTG_RCDW_TBL[GRADE]);
        CMD_PRE: begin
          need(t_wl[b], DCTG_WR_TBL[GRADE]);
          need(t_act[b], DCTG_RAS_TBL[GRADE]);
          t_pre[b] = now;
        end
        CMD_REF: begin
          need(t_ref, DCTG_RFC_TBL[GRADE]);
          t_ref = now;
        end
        CMD_MRS: t_mrs = now;
        CMD_SRX: t_srx = now;
        default: ;
      endcase
      // Last data beat is judged from the edge after the one that samples it
      if (wr_last.valid) begin
        t_wl[wr_last.bank] = now + 1;
        t_wl_any = now + 1;
        if (wr_last.autopre) t_dal[wr_last.bank] = now + 1;
      end
    end
    now++;
  end
endmodule
`default_nettype wire

// *** test/test_dctg_guard.sv ***
// Self-checking testbench for the DRAM command timing guard
`timescale 1ns/10ps
`default_nettype none
module test_dctg_guard import dctg_pkg::*;;
  // ==========================================================
  // Set-up: third table entry, short self refresh and row limits
  localparam int unsigned G    = 2;
  localparam int unsigned XSR  = 150;
  localparam int unsigned RMAX = 200;
  logic                  clk;
  logic                  rst_n;
  logic                  req_valid;
  logic                  req_ack;
  logic                  refresh_due;
  logic                  self_refresh;
  logic [DCTG_NBANK-1:0] row_overdue;
  dctg_req_type          req;
  dctg_req_type          dram_cmd;
  dctg_wrdone_type       wr_last;
  int                    now;
  int                    last;
  int                    mismatches;
  int                    samples_checked;
  int                    violations;
  logic                  alt_ack;
  int                    alt_gap;
  // Activate spacing in the wider mode: table count or 12 ns rounded up
  localparam int unsigned ALT_RRD =
    DCTG_RRD_ALT_PS / DCTG_CLK_PS + ((DCTG_RRD_ALT_PS % DCTG_CLK_PS) != 0);
  localparam int unsigned ALT_EXP =
    (ALT_RRD > DCTG_RRD_TBL[G]) ? ALT_RRD : DCTG_RRD_TBL[G];

  dctg_guard #(.GRADE(G), .XSR_CYC(XSR), .RAS_MAX_CYC(RMAX)) dut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ack(req_ack), .wr_last(wr_last), .dram_cmd(dram_cmd),
    .refresh_due(refresh_due), .row_overdue(row_overdue),
    .self_refresh(self_refresh));

  // Same requests into the mode that drops the four activate window
  dctg_guard #(.GRADE(G), .USE_RRD_ALT(1), .XSR_CYC(XSR),
    .RAS_MAX_CYC(RMAX)) dut_alt (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ack(alt_ack), .wr_last(wr_last), .dram_cmd(),
    .refresh_due(), .row_overdue(), .self_refresh());

  // Edges from the last acknowledged command to each wide-mode accept
  always @(posedge clk) if (alt_ack) alt_gap <= now - last;

  dctg_dram_model #(.GRADE(G), .XSR_CYC(XSR)) u_dram (
    .clk(clk), .rst_n(rst_n), .cmd(dram_cmd), .wr_last(wr_last),
    .violations(violations));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) now <= now + 1;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // Holds the request until acknowledged; gap is from the previous command
  task automatic step(input dctg_cmd_type c, input int b, input int gap);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{c, 3'(b)};
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (req_ack === 1'b1) break;
    end
    if (n == 400) check(req_ack, 1'b1);
    if (gap >= 0) check(now - last, gap);
    last = now;
    req_valid = 1'b0;
  endtask

  // One-cycle last data beat, raised in the cycle that follows the write
  task automatic wdone(input int b, input logic ap);
    wr_last = '{1'b1, 3'(b), ap};
    @(negedge clk);
    wr_last = '0;
  endtask

  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    do_reset;
    check(refresh_due, 1'b0);
    @(negedge clk);
    check({req_ack, dram_cmd, row_overdue, self_refresh}, '0);
    check(refresh_due, 1'b1);
    step(CMD_REF, 0, -1);
    repeat (2) @(negedge clk);
    check(refresh_due, 1'b0);
    step(CMD_ACT, 0, DCTG_RFC_TBL[G]);
    $display("test reset and refresh done");
  endtask

  task automatic t_act;
    do_reset;
    step(CMD_ACT, 0, -1);
    step(CMD_ACT, 1, DCTG_RRD_TBL[G]);
    step(CMD_WR, 1, DCTG_RCDW_TBL[G]);
    step(CMD_ACT, 2, -1);
    step(CMD_RD, 2, DCTG_RCDR_TBL[G]);
    $display("test activate spacing done");
  endtask

  task automatic t_faw;
    do_reset;
    step(CMD_ACT, 0, -1);
    for (int b = 1; b < 4; b++) step(CMD_ACT, b, DCTG_RRD_TBL[G]);
    step(CMD_ACT, 4, DCTG_FAW_CYC - 3 * DCTG_RRD_TBL[G]);
    check(alt_gap, ALT_EXP);
    $display("test four activate window done");
  endtask

  // Idle gap lets the row open time lapse before the recovery counts
  task automatic t_write;
    do_reset;
    step(CMD_ACT, 0, -1);
    repeat (20) @(negedge clk);
    step(CMD_WR, 0, -1);
    wdone(0, 1'b0);
    step(CMD_RD, 0, 1 + DCTG_CDLR_TBL[G]);
    step(CMD_PRE, 0, DCTG_WR_TBL[G] - DCTG_CDLR_TBL[G]);
    step(CMD_ACT, 0, DCTG_RP_TBL[G]);
    $display("test write recovery done");
  endtask

  task automatic t_autopre;
    do_reset;
    step(CMD_ACT, 2, -1);
    repeat (20) @(negedge clk);
    step(CMD_WR, 2, -1);
    wdone(2, 1'b1);
    step(CMD_ACT, 2, 1 + DCTG_DAL_TBL[G]);
    $display("test auto precharge done");
  endtask

  task automatic t_mrs;
    do_reset;
    step(CMD_MRS, 0, -1);
    step(CMD_ACT, 0, DCTG_MRD_TBL[G]);
    $display("test mode set done");
  endtask

  task automatic t_selfref;
    do_reset;
    step(CMD_SRE, 0, -1);
    check(self_refresh, 1'b1);
    step(CMD_SRX, 0, -1);
    check(self_refresh, 1'b0);
    step(CMD_ACT, 0, DCTG_XSNR_CYC);
    step(CMD_RD, 0, XSR - DCTG_XSNR_CYC);
    $display("test self refresh exit done");
  endtask

  task automatic t_rowmax;
    do_reset;
    step(CMD_ACT, 1, -1);
    step(CMD_PRE, 1, DCTG_RAS_TBL[G]);
    step(CMD_ACT, 1, DCTG_RC_TBL[G] - DCTG_RAS_TBL[G]);
    repeat (RMAX - 10) @(negedge clk);
    check(row_overdue, '0);
    repeat (20) @(negedge clk);
    check(row_overdue, 8'h02);
    step(CMD_PRE, 1, -1);
    repeat (2) @(negedge clk);
    check(row_overdue, '0);
    $display("test row open limits done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    wr_last = '0;
    t_reset;
    t_act;
    t_faw;
    t_write;
    t_autopre;
    t_mrs;
    t_selfref;
    t_rowmax;
    check(violations, 0);
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
